// [design/timer_count_ctrl.sv]
/*
  Count clock, edge and clear source selection for six timer channels,
  with one count-control register per channel behind an APB slave.
  Assumes the counters, compare/capture, mode and phase logic lie outside
  and exchange single-cycle pulses on sys_clk.
*/
// The APB slave port and the register addresses were left to the implementer.
// Operation
// [R1] Six 8-bit count-control registers reset to zero on reset and in standby.
// [R2] Software should change a channel's settings only while its counter is stopped.
// [R3] Channels 0 and 3 clear codes 000 none, 001 reg A, 010 reg B, 011 sync clear.
// [R4] Channels 0 and 3 clear codes 100 none, 101 reg C, 110 reg D, 111 sync clear.
// [R5] A reg C or D used as buffer never clears the counter.
// [R6] Channels 1, 2, 4, 5 keep bit 7 at zero and use a two-bit clear field.
// [R7] Sync clear acts only for channels whose sync bit is set.
// [R8] Edge field 00 rising, 01 falling, 1x both edges.
// [R9] Both-edge counting ticks on every edge of the chosen clock.
// [R10] Phase counting mode on channels 1, 2, 4, 5 overrides the edge field.
// [R11] Edge choice is ignored for the undivided clock and the cascade source.
// [R12] A three-bit prescale field picks each channel's clock independently.
// [R13] Channels 0, 1, 2 offer their own divider, pin and cascade sets.
// [R14] Channels 3, 4, 5 offer their own divider, pin and cascade sets.
// [R15] Channel 0 codes 0-3 pick /1 /4 /16 /64 and codes 4-7 pins A to D.
// [R16] Channel 1 cascades from channel 2 and channel 4 from channel 5, code 111.
`default_nettype none

module timer_count_ctrl #(
  parameter int NCH = timer_ccs_pkg::NCH
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Hardware standby pin
  input  wire logic              hw_standby,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // External clock pins
  input  wire logic              ext_clock_in_a,
  input  wire logic              ext_clock_in_b,
  input  wire logic              ext_clock_in_c,
  input  wire logic              ext_clock_in_d,
  // Counter side events
  input  wire logic [5:0]        ovf_unf,
  input  wire logic [5:0]        match_a,
  input  wire logic [5:0]        match_b,
  input  wire logic [1:0]        match_c,
  input  wire logic [1:0]        match_d,
  input  wire logic [1:0]        buf_c_mode,
  input  wire logic [1:0]        buf_d_mode,
  input  wire logic [5:0]        phase_mode,
  input  wire logic [5:0]        phase_tick,
  // Counter controls
  output logic [5:0]             count_tick,
  output logic [5:0]             counter_clear
);

  initial begin
    if (NCH != 6) $error("timer_count_ctrl: exactly six channels supported");
  end

  // Reset release
  logic rst_ff1_q;
  logic rst_ff2_q;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff1_q <= 1'b0;
      rst_ff2_q <= 1'b0;
    end else begin
      rst_ff1_q <= 1'b1;
      rst_ff2_q <= rst_ff1_q;
    end
  end

  assign rst_sync_n = rst_ff2_q;

  // Pin synchronisers
  logic [4:0] pin_raw;
  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  assign pin_raw = {hw_standby, ext_clock_in_d, ext_clock_in_c,
                    ext_clock_in_b, ext_clock_in_a};

  for (genvar p = 0; p < 5; p++) begin : g_pin
    pin_edge_sync u_sync (
      .sys_clk    (sys_clk),
      .rst_sync_n (rst_sync_n),
      .pin        (pin_raw[p]),
      .level      (pin_lvl[p]),
      .rise       (pin_rise[p]),
      .fall       (pin_fall[p])
    );
  end

  logic standby;
  assign standby = pin_lvl[4];

  // Prescaler
  logic [5:0]                         tap_rise;
  logic [5:0]                         tap_fall;
  logic [timer_ccs_pkg::PRESC_W-1:0]  presc_cnt;

  prescale_taps #(
    .W (timer_ccs_pkg::PRESC_W)
  ) u_presc (
    .sys_clk    (sys_clk),
    .rst_sync_n (rst_sync_n),
    .tap_rise   (tap_rise),
    .tap_fall   (tap_fall),
    .count      (presc_cnt)
  );

  // APB decode
  logic       apb_access;
  logic       apb_done;
  logic       aligned;
  logic [2:0] word_idx;
  logic       hit_ctl;
  logic       hit_sync;
  logic       hit_stat;
  logic       hit_any;
  logic       wr_en;

  assign apb_access = psel & penable;
  assign apb_done   = apb_access & pready;
  assign aligned    = (paddr[1:0] == 2'h0);
  assign word_idx   = paddr[4:2];
  assign hit_ctl    = aligned && (paddr < timer_ccs_pkg::OFF_SYNC);
  assign hit_sync   = (paddr == timer_ccs_pkg::OFF_SYNC);
  assign hit_stat   = (paddr == timer_ccs_pkg::OFF_STAT);
  assign hit_any    = hit_ctl | hit_sync | hit_stat;
  assign wr_en      = apb_done & pwrite & hit_any;

  // Registers
  logic [7:0] ctl_q [6];
  logic [7:0] ctl_d [6];
  logic [5:0] sync_q;
  logic [5:0] sync_d;

  for (genvar c = 0; c < 6; c++) begin : g_reg
    localparam logic [7:0] MASK =
      timer_ccs_pkg::NARROW_CH[c] ? timer_ccs_pkg::NARROW_MSK : 8'hFF;
    assign ctl_d[c] = (wr_en && hit_ctl && word_idx == 3'(c)) ?
                      (pwdata[7:0] & MASK) : ctl_q[c]; // [R6]

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) ctl_q[c] <= timer_ccs_pkg::CTL_RESET; // [R1]
      else if (standby) ctl_q[c] <= timer_ccs_pkg::CTL_RESET; // [R1]
      else ctl_q[c] <= ctl_d[c];
    end
  end

  assign sync_d = (wr_en && hit_sync) ? pwdata[5:0] : sync_q;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) sync_q <= timer_ccs_pkg::SYNC_RESET;
    else if (standby) sync_q <= timer_ccs_pkg::SYNC_RESET;
    else sync_q <= sync_d;
  end

  // Read data
  logic [31:0] rd_mux;

  assign rd_mux = hit_ctl  ? {24'h000000, ctl_q[word_idx]} :
                  hit_sync ? {26'h0000000, sync_q} :
                  hit_stat ? {20'h00000, presc_cnt} : 32'h00000000;

  // APB answer: one wait state
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_access & ~pready;
      prdata  <= (apb_access & ~pready & ~pwrite) ? rd_mux : prdata;
      pslverr <= apb_access & ~pready & ~hit_any;
    end
  end

  // Pick a pulse by edge field
  function automatic logic edge_pick(input logic [1:0] edg,
                                     input logic r, input logic f);
    logic v;
    v = 1'b0;
    if (edg[1]) v = r | f; // [R9]
    else if (edg == timer_ccs_pkg::EDGE_FALL) v = f;
    else v = r;
    return v; // [R8]
  endfunction : edge_pick

  // Tick for one channel from its source
  function automatic logic src_tick(input timer_ccs_pkg::clk_src_t s,
                                    input logic [1:0] edg,
                                    input logic [5:0] tr,
                                    input logic [5:0] tf,
                                    input logic [3:0] er,
                                    input logic [3:0] ef,
                                    input logic casc);
    logic v;
    v = 1'b0;
    case (s)
      timer_ccs_pkg::SRC_P1:    v = 1'b1; // [R11]
      timer_ccs_pkg::SRC_P4:    v = edge_pick(edg, tr[0], tf[0]);
      timer_ccs_pkg::SRC_P16:   v = edge_pick(edg, tr[1], tf[1]);
      timer_ccs_pkg::SRC_P64:   v = edge_pick(edg, tr[2], tf[2]);
      timer_ccs_pkg::SRC_P256:  v = edge_pick(edg, tr[3], tf[3]);
      timer_ccs_pkg::SRC_P1024: v = edge_pick(edg, tr[4], tf[4]);
      timer_ccs_pkg::SRC_P4096: v = edge_pick(edg, tr[5], tf[5]);
      timer_ccs_pkg::SRC_EXA:   v = edge_pick(edg, er[0], ef[0]);
      timer_ccs_pkg::SRC_EXB:   v = edge_pick(edg, er[1], ef[1]);
      timer_ccs_pkg::SRC_EXC:   v = edge_pick(edg, er[2], ef[2]);
      timer_ccs_pkg::SRC_EXD:   v = edge_pick(edg, er[3], ef[3]);
      timer_ccs_pkg::SRC_CASC:  v = casc; // [R11]
      default:                  v = 1'b0;
    endcase
    return v;
  endfunction : src_tick

  // Clear from the channel's own compare or capture sources
  function automatic logic own_clear(input logic [2:0] code,
                                     input logic ma, input logic mb,
                                     input logic mc, input logic md,
                                     input logic bc, input logic bd);
    logic v;
    v = 1'b0;
    case (code)
      timer_ccs_pkg::CLR_A: v = ma; // [R3]
      timer_ccs_pkg::CLR_B: v = mb; // [R3]
      timer_ccs_pkg::CLR_C: v = mc & ~bc; // [R4] [R5]
      timer_ccs_pkg::CLR_D: v = md & ~bd; // [R4] [R5]
      default:              v = 1'b0;
    endcase
    return v;
  endfunction : own_clear

  // Per-channel selection
  logic [5:0] tick_d;
  logic [5:0] own_clr;
  logic [5:0] sync_sel;
  logic [5:0] clear_d;
  logic [5:0] sync_src;

  assign sync_src = own_clr & sync_q;

  for (genvar c = 0; c < 6; c++) begin : g_ch
    localparam bit NARROW = timer_ccs_pkg::NARROW_CH[c];
    localparam int WI = (c == 3) ? 1 : 0;
    timer_ccs_pkg::clk_src_t src;
    logic [1:0] edg;
    logic [2:0] clr_code;
    logic       casc;
    logic       mc;
    logic       md;
    logic       bc;
    logic       bd;
    logic       norm_tick;

    assign src = timer_ccs_pkg::src_of(c, ctl_q[c][2:0]); // [R12] [R13] [R14] [R15]
    assign edg = ctl_q[c][timer_ccs_pkg::EDGE_MSB:timer_ccs_pkg::EDGE_LSB];
    assign clr_code = ctl_q[c][timer_ccs_pkg::CLR_MSB:timer_ccs_pkg::CLR_LSB];
    assign casc = (c == 1) ? ovf_unf[2] : (c == 4) ? ovf_unf[5] : 1'b0; // [R16]
    assign mc = NARROW ? 1'b0 : match_c[WI];
    assign md = NARROW ? 1'b0 : match_d[WI];
    assign bc = NARROW ? 1'b0 : buf_c_mode[WI];
    assign bd = NARROW ? 1'b0 : buf_d_mode[WI];
    assign norm_tick = src_tick(src, edg, tap_rise, tap_fall,
                                pin_rise[3:0], pin_fall[3:0], casc);
    assign tick_d[c] = (NARROW && phase_mode[c]) ? phase_tick[c] : norm_tick; // [R10]
    assign own_clr[c] = own_clear(clr_code, match_a[c], match_b[c],
                                  mc, md, bc, bd);
    assign sync_sel[c] = (clr_code[1:0] == timer_ccs_pkg::CLR_SYNC); // [R3] [R4]
    assign clear_d[c] = own_clr[c] |
                        (sync_sel[c] & sync_q[c] &
                         (|(sync_src & ~(6'h01 << c)))); // [R7]
  end

  // Registered outputs
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_tick    <= 6'h00;
      counter_clear <= 6'h00;
    end else begin
      count_tick    <= standby ? 6'h00 : tick_d;
      counter_clear <= standby ? 6'h00 : clear_d;
    end
  end

endmodule : timer_count_ctrl

`default_nettype wire

// [design/timer_ccs_pkg.sv]
/*
  Shared constants and source decode for the per-channel count control block.
  Assumes one 125 MHz system clock and six counter channels.
*/
`default_nettype none

package timer_ccs_pkg;

  localparam int          NCH        = 6;
  localparam int          ADDR_W     = 8;
  localparam int          PRESC_W    = 12;
  localparam int          NTAPS      = 6;
  localparam int          SYS_CLK_MHZ = 125;

  // Register byte addresses
  localparam logic [7:0]  OFF_CTL0   = 8'h00;
  localparam logic [7:0]  OFF_SYNC   = 8'h18;
  localparam logic [7:0]  OFF_STAT   = 8'h1C;

  // Reset values
  localparam logic [7:0]  CTL_RESET  = 8'h00;
  localparam logic [5:0]  SYNC_RESET = 6'h00;

  // Field positions
  localparam int          CLR_MSB    = 7;
  localparam int          CLR_LSB    = 5;
  localparam int          EDGE_MSB   = 4;
  localparam int          EDGE_LSB   = 3;
  localparam int          PSC_MSB    = 2;
  localparam int          PSC_LSB    = 0;

  // Channels with a two-bit clear field
  localparam logic [5:0]  NARROW_CH  = 6'h36;
  localparam logic [7:0]  NARROW_MSK = 8'h7F;

  // Clear source codes
  localparam logic [2:0]  CLR_A      = 3'h1;
  localparam logic [2:0]  CLR_B      = 3'h2;
  localparam logic [2:0]  CLR_C      = 3'h5;
  localparam logic [2:0]  CLR_D      = 3'h6;
  localparam logic [1:0]  CLR_SYNC   = 2'h3;

  // Edge codes
  localparam logic [1:0]  EDGE_FALL  = 2'h1;

  typedef enum logic [3:0] {
    SRC_P1, SRC_P4, SRC_P16, SRC_P64, SRC_P256, SRC_P1024, SRC_P4096,
    SRC_EXA, SRC_EXB, SRC_EXC, SRC_EXD, SRC_CASC
  } clk_src_t;

  // Prescale code to clock source, per channel
  function automatic clk_src_t src_of(input int ch, input logic [2:0] psc);
    clk_src_t s;
    s = SRC_P1;
    case (psc)
      3'h0: s = SRC_P1;
      3'h1: s = SRC_P4;
      3'h2: s = SRC_P16;
      3'h3: s = SRC_P64;
      3'h4: s = SRC_EXA;
      3'h5: s = (ch == 0 || ch == 1 || ch == 2) ? SRC_EXB :
                (ch == 3) ? SRC_P1024 : SRC_EXC;
      3'h6: s = (ch == 0 || ch == 2) ? SRC_EXC :
                (ch == 4) ? SRC_P1024 : SRC_P256;
      default: s = (ch == 0) ? SRC_EXD : (ch == 2) ? SRC_P1024 :
                   (ch == 3) ? SRC_P4096 : (ch == 5) ? SRC_EXD : SRC_CASC;
    endcase
    return s;
  endfunction : src_of

endpackage : timer_ccs_pkg

`default_nettype wire

// [design/prescale_taps.sv]
/*
  Free-running prescaler giving rise and fall pulses of each divided clock.
  Assumes a synchronous active-low reset from the parent.
*/
`default_nettype none

module prescale_taps #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_sync_n,
  // Divided clock edges, taps /4 /16 /64 /256 /1024 /4096
  output logic [5:0]        tap_rise,
  output logic [5:0]        tap_fall,
  output logic [W-1:0]      count
);

  logic [W-1:0] cnt_q;

  initial begin
    if (W < 12) $error("prescale_taps: W must be at least 12");
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) cnt_q <= '0;
    else cnt_q <= cnt_q + 1'b1;
  end

  // Tap i divides by 4**(i+1)
  for (genvar i = 0; i < 6; i++) begin : g_tap
    localparam int K = 2 * i + 2;
    assign tap_rise[i] = &cnt_q[K-1:0];
    assign tap_fall[i] = (&cnt_q[K-2:0]) & ~cnt_q[K-1];
  end

  assign count = cnt_q;

endmodule : prescale_taps

`default_nettype wire

// [design/pin_edge_sync.sv]
/*
  Two-stage synchroniser for an asynchronous pin with edge pulses.
  Assumes the pin may change at any time relative to sys_clk.
*/
`default_nettype none

module pin_edge_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_sync_n,
  // Pin and results
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
  assign fall  = ~sync_q & last_q;

endmodule : pin_edge_sync

`default_nettype wire

// [bench/timer_count_ctrl_checker.sv]
/* Checker for tick and clear outputs of the count control block.
   Assumes it is bound to timer_count_ctrl and sees only its ports. */
`default_nettype none
module timer_count_ctrl_checker (
  // Clock, reset, standby
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        hw_standby,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  // Events and controls
  input wire logic [5:0]  match_a,
  input wire logic [1:0]  match_c,
  input wire logic [1:0]  buf_c_mode,
  input wire logic [5:0]  phase_mode,
  input wire logic [5:0]  phase_tick,
  input wire logic [5:0]  count_tick,
  input wire logic [5:0]  counter_clear
);
  logic [7:0] ctl_q;
  logic [2:0] up_q;
  wire        rdy = up_q == 3'h7;
  wire        wr0 = psel && penable && pwrite && pready && paddr == 8'h00;
  wire        r4  = !ctl_q[4] && ctl_q[2:0] == 3'h1;
  wire        b4  = ctl_q[4] && ctl_q[2:0] == 3'h1;

  // Shadow of channel 0 control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= 8'h00;
      up_q  <= 3'h0;
    end else if (hw_standby) begin
      ctl_q <= 8'h00;
      up_q  <= 3'h0;
    end else begin
      if (wr0) ctl_q <= pwdata[7:0];
      if (!rdy) up_q <= up_q + 3'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_gap3;
    (!count_tick[0] || !r4) [*3] ##1 (count_tick[0] || !r4);
  endsequence
  sequence s_gap1;
    (!count_tick[0] || !b4) ##1 (count_tick[0] || !b4);
  endsequence

  property p_clear_a;
    rdy && ctl_q[7:5] == timer_ccs_pkg::CLR_A && match_a[0] |=> counter_clear[0];
  endproperty
  a_clear_a: assert property (p_clear_a) else $error("no clear after A");
  property p_clear_c;
    rdy && ctl_q[7:5] == timer_ccs_pkg::CLR_C && match_c[0] && !buf_c_mode[0]
      |=> counter_clear[0];
  endproperty
  a_clear_c: assert property (p_clear_c) else $error("no clear after C");
  property p_buf_c;
    rdy && ctl_q[7:5] == timer_ccs_pkg::CLR_C && buf_c_mode[0] |=> !counter_clear[0];
  endproperty
  a_buf_c: assert property (p_buf_c) else $error("clear from buffer C");
  property p_tick1;
    rdy && ctl_q[2:0] == 3'h0 && $past(ctl_q[2:0], 2) == 3'h0 |-> count_tick[0];
  endproperty
  a_tick1: assert property (p_tick1) else $error("undivided tick missing");
  property p_rise;
    rdy && r4 && $past(ctl_q[4:0]) == ctl_q[4:0] && count_tick[0] |=> s_gap3;
  endproperty
  a_rise: assert property (p_rise) else $error("single edge spacing");
  property p_both;
    rdy && b4 && $past(ctl_q[4:0]) == ctl_q[4:0] && count_tick[0] |=> s_gap1;
  endproperty
  a_both: assert property (p_both) else $error("both edge spacing");
  property p_phase;
    rdy && phase_mode[1] |=> count_tick[1] == $past(phase_tick[1]);
  endproperty
  a_phase: assert property (p_phase) else $error("phase tick not followed");
  property p_bit7;
    psel && pready && !pwrite && (paddr == 8'h04 || paddr == 8'h08 || paddr == 8'h10
      || paddr == 8'h14) |-> !prdata[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("reserved bit reads one");
endmodule : timer_count_ctrl_checker

bind timer_count_ctrl timer_count_ctrl_checker i_chk (.sys_clk, .rst_n, .hw_standby,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .match_a, .match_c,
  .buf_c_mode, .phase_mode, .phase_tick, .count_tick, .counter_clear);
`default_nettype wire

// [bench/tb_timer_count_ctrl.sv]
/* Self-checking bench for timer_count_ctrl.
   Assumes the bound checker; drives APB, pins and counter events itself. */
`default_nettype none
module tb_timer_count_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_n, hw_standby, psel, penable, pwrite, pready, pslverr, er_s;
  logic        ext_clock_in_a, ext_clock_in_b, ext_clock_in_c, ext_clock_in_d;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_s;
  logic [5:0]  ovf_unf, match_a, match_b, phase_mode, phase_tick, count_tick, counter_clear;
  logic [1:0]  match_c, match_d, buf_c_mode, buf_d_mode;
  logic [15:0] cyc;
  int          n_mismatch, samples_checked;
  int          tick_n [6];
  logic [7:0]  cfg [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                            8'h09, 8'h11, 8'h18, 8'h1F};
  int          exp_n [12][6] = '{'{6{4096}}, '{6{1024}}, '{6{256}}, '{6{64}}, '{6{256}},
    '{128, 128, 128, 4, 64, 64}, '{64, 16, 64, 16, 4, 16}, '{32, 512, 4, 1, 512, 32},
    '{6{1024}}, '{6{2048}}, '{6{4096}}, '{64, 512, 8, 2, 512, 64}};

  timer_count_ctrl i_dut (.sys_clk, .rst_n, .hw_standby, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .ext_clock_in_a, .ext_clock_in_b, .ext_clock_in_c,
    .ext_clock_in_d, .ovf_unf, .match_a, .match_b, .match_c, .match_d, .buf_c_mode,
    .buf_d_mode, .phase_mode, .phase_tick, .count_tick, .counter_clear);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Pins, cascade pulses and phase requests
  always @(posedge sys_clk) begin
    cyc <= cyc + 16'h1;
    {ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a} <= cyc[6:3];
    ovf_unf <= {cyc[2:0] == 3'h0, 2'h0, cyc[2:0] == 3'h0, 2'h0};
    phase_tick <= {6{cyc[1:0] == 2'h0}};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input int tol);
    samples_checked++;
    if ($isunknown(got) || got > want + tol || got + tol < want) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd_s, er_s);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0, rd_s, er_s);
    chk(rd_s, want, 0);
  endtask : rchk

  task automatic hit(input logic [5:0] a, b, input logic [1:0] c, d, output logic [5:0] seen);
    @(posedge sys_clk);
    {match_a, match_b, match_c, match_d} <= {a, b, c, d};
    @(posedge sys_clk);
    {match_a, match_b, match_c, match_d} <= '0;
    seen = '0;
    repeat (3) begin
      @(negedge sys_clk);
      seen |= counter_clear;
    end
  endtask : hit

  task automatic count_win;
    tick_n = '{default: 0};
    repeat (4096) begin
      @(negedge sys_clk);
      foreach (tick_n[i]) tick_n[i] += int'(count_tick[i]);
    end
  endtask : count_win

  task automatic t_regs;
    for (int i = 0; i < 7; i++) rchk(8'(i * 4), 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(8'(i * 4), 32'hFFFF_FFFF);
      rchk(8'(i * 4), (i % 3 == 0) ? 32'hFF : 32'h7F);
    end
    wr(8'h18, 32'hFFFF_FFFF);
    rchk(8'h18, 32'h3F);
    apb(1'b0, 8'h20, 32'h0, rd_s, er_s);
    chk({rd_s[30:0], er_s}, 32'h1, 0);
  endtask : t_regs

  task automatic t_standby;
    @(posedge sys_clk);
    hw_standby <= 1'b1;
    repeat (6) @(posedge sys_clk);
    hw_standby <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 7; i++) rchk(8'(i * 4), 32'h0);
  endtask : t_standby

  task automatic t_clear;
    logic [5:0] seen;
    for (int ch = 0; ch < 6; ch += 3)
      for (int c = 0; c < 8; c++) begin
        wr(8'(ch * 4), 32'(c) << 5);
        for (int s = 0; s < 4; s++) begin
          hit(6'(s == 0) << ch, 6'(s == 1) << ch, 2'(s == 2) << ch / 3,
              2'(s == 3) << ch / 3, seen);
          chk(32'(seen), 32'(c == 1 && s == 0 || c == 2 && s == 1 || c == 5 && s == 2
              || c == 6 && s == 3) << ch, 0);
        end
      end
  endtask : t_clear

  task automatic t_buffer;
    logic [5:0] seen;
    wr(8'h00, 32'hA0);
    buf_c_mode <= 2'h1;
    hit(6'h00, 6'h00, 2'h1, 2'h0, seen);
    chk(32'(seen), 32'h0, 0);
    wr(8'h00, 32'hC0);
    buf_d_mode <= 2'h1;
    hit(6'h00, 6'h00, 2'h0, 2'h1, seen);
    chk(32'(seen), 32'h0, 0);
    {buf_c_mode, buf_d_mode} <= 4'h0;
  endtask : t_buffer

  task automatic t_sync;
    logic [5:0] seen;
    wr(8'h18, 32'h3);
    wr(8'h00, 32'h20);
    wr(8'h04, 32'h60);
    hit(6'h01, 6'h00, 2'h0, 2'h0, seen);
    chk(32'(seen), 32'h3, 0);
    wr(8'h18, 32'h1);
    hit(6'h01, 6'h00, 2'h0, 2'h0, seen);
    chk(32'(seen), 32'h1, 0);
  endtask : t_sync

  task automatic t_ticks;
    for (int e = 0; e < 12; e++) begin
      for (int ch = 0; ch < 6; ch++) wr(8'(ch * 4), 32'(cfg[e]));
      repeat (16) @(posedge sys_clk);
      count_win();
      for (int ch = 0; ch < 6; ch++) begin
        chk(tick_n[ch], exp_n[e][ch], 1);
      end
    end
  endtask : t_ticks

  task automatic t_phase;
    for (int ch = 0; ch < 6; ch++) wr(8'(ch * 4), 32'h0);
    phase_mode <= 6'h03;
    repeat (4) @(posedge sys_clk);
    count_win();
    chk(tick_n[0], 4096, 1);
    chk(tick_n[1], 1024, 1);
    @(posedge sys_clk);
    phase_mode <= 6'h00;
  endtask : t_phase

  task automatic summarize;
    $display("Compared %0d, mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial begin
    repeat (80000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    {hw_standby, psel, penable, pwrite, paddr, pwdata, match_a, match_b, match_c} = '0;
    {match_d, buf_c_mode, buf_d_mode, phase_mode, phase_tick, ovf_unf, cyc} = '0;
    {ext_clock_in_a, ext_clock_in_b, ext_clock_in_c, ext_clock_in_d} = 4'h0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_standby();
    t_clear();
    t_buffer();
    t_sync();
    t_ticks();
    t_phase();
    summarize();
  end
endmodule : tb_timer_count_ctrl
`default_nettype wire
